// [core/reopg_rail_ctrl.v]
// Register file, rail enable merge and three status delay timers.
// Assumes register strobes come from the I2C slave on this clock.
`timescale 1ns/10ps
`include "reopg_defines.vh"
module reopg_rail_ctrl
#(
  parameter MS_CYCLES = `REOPG_MS_CYCLES
)
(
  input wire i_core_clk,
  input wire i_arst_n,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  input wire [5:0] i_control_input_pins,
  input wire [15:0] i_pin_request,
  input wire i_shared_sel_linear,
  input wire [2:0] i_host_ctrl_mode,
  input wire [2:0] i_group_in_regulation,
  output reg [15:0] o_rail_enable,
  output reg o_first_status_output,
  output reg o_second_status_output,
  output reg o_fourth_status_output,
  output reg o_termination_enable
);
  // Rail index order of o_rail_enable and i_pin_request:
  // 0..5 step-down one..six, 6 first switch, 7 second linear,
  // 8 second switch, 9 third switch, 10 first linear,
  // 11 termination, 12..15 spare.
  localparam RI_SW1 = 6;
  localparam RI_SW2 = 8;
  localparam RI_SW3 = 9;
  localparam RI_LIN1 = 10;
  localparam RI_TERM = 11;
  reg [7:0] delay_q;
  reg [7:0] disable_q;
  reg [7:0] force_q;
  reg [5:0] pins_m_q;
  reg [5:0] pins_q;
  reg [2:0] qual_m_q;
  reg [2:0] qual_q;
  reg [16:0] div_q;
  reg tick_q;
  reg [15:0] rail_d;
  reg [15:0] allow;
  reg [15:0] force_on;
  wire good1;
  wire good2;
  wire good4;
  // ==========================================
  // Registers
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      delay_q <= `REOPG_RST_DELAY;
      disable_q <= `REOPG_RST_DISABLE;
      force_q <= `REOPG_RST_FORCE;
      o_reg_rdata <= 8'h00;
    end
    else
    begin
      if (i_reg_wr)
      begin
        case (i_reg_addr)
          `REOPG_ADDR_DELAY: delay_q <= i_reg_wdata;
          // Reserved low bits kept at zero
          `REOPG_ADDR_DISABLE:
            disable_q <= i_reg_wdata & `REOPG_RSVD_MASK;
          `REOPG_ADDR_FORCE: force_q <= i_reg_wdata;
          default: force_q <= force_q;
        endcase
      end
      if (i_reg_rd)
      begin
        case (i_reg_addr)
          `REOPG_ADDR_DELAY: o_reg_rdata <= delay_q;
          `REOPG_ADDR_DISABLE: o_reg_rdata <= disable_q;
          `REOPG_ADDR_FORCE: o_reg_rdata <= force_q;
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end
  // ==========================================
  // Synchronisers and tick divider
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pins_m_q <= 6'h00;
      pins_q <= 6'h00;
      qual_m_q <= 3'h0;
      qual_q <= 3'h0;
      div_q <= 17'h00000;
      tick_q <= 1'b0;
    end
    else
    begin
      pins_m_q <= i_control_input_pins;
      pins_q <= pins_m_q;
      qual_m_q <= i_group_in_regulation;
      qual_q <= qual_m_q;
      // Tenth-millisecond tick keeps the delay within tolerance
      if (div_q == MS_CYCLES / `REOPG_TICKS_PER_MS - 1)
      begin
        div_q <= 17'h00000;
        tick_q <= 1'b1;
      end
      else
      begin
        div_q <= div_q + 17'h00001;
        tick_q <= 1'b0;
      end
    end
  end
  // ==========================================
  // Delay decode
  function [7:0] code_ms;
    input [2:0] code;
    begin
      case (code)
        3'h0: code_ms = `REOPG_D0_MS;
        3'h1: code_ms = `REOPG_D1_MS;
        3'h2: code_ms = `REOPG_D2_MS;
        3'h3: code_ms = `REOPG_D3_MS;
        3'h4: code_ms = `REOPG_D4_MS;
        3'h5: code_ms = `REOPG_D5_MS;
        3'h6: code_ms = `REOPG_D7_MS;
        default: code_ms = `REOPG_D7_MS;
      endcase
    end
  endfunction
  reopg_delay_timer u_timer1
  (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_ms_tick(tick_q),
    .i_qualified(qual_q[0]),
    .i_delay_ms(code_ms({1'b0,
      delay_q[`REOPG_F1_HI:`REOPG_F1_LO]})),
    .o_good(good1)
  );
  reopg_delay_timer u_timer2
  (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_ms_tick(tick_q),
    .i_qualified(qual_q[1]),
    .i_delay_ms(code_ms(delay_q[`REOPG_F2_HI:`REOPG_F2_LO])),
    .o_good(good2)
  );
  reopg_delay_timer u_timer4
  (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_ms_tick(tick_q),
    .i_qualified(qual_q[2]),
    .i_delay_ms(code_ms(delay_q[`REOPG_F4_HI:`REOPG_F4_LO])),
    .o_good(good4)
  );
  // ==========================================
  // Rail enable merge
  always @*
  begin
    allow = 16'hFFFF;
    allow[RI_SW2] = disable_q[`REOPG_DIS_SW2];
    allow[RI_SW1] = disable_q[`REOPG_DIS_SW1];
    allow[RI_TERM] = disable_q[`REOPG_DIS_TERM];
    if (i_shared_sel_linear)
      allow[RI_LIN1] = disable_q[`REOPG_DIS_SHARED];
    else
      allow[RI_SW3] = disable_q[`REOPG_DIS_SHARED];
    force_on = {8'h00, force_q};
    rail_d = (i_pin_request | force_on) & allow;
  end
  // ==========================================
  // Outputs
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rail_enable <= 16'h0000;
      o_first_status_output <= 1'b0;
      o_second_status_output <= 1'b0;
      o_fourth_status_output <= 1'b0;
      o_termination_enable <= 1'b0;
    end
    else
    begin
      o_rail_enable <= rail_d;
      // Host-controlled outputs are driven elsewhere; held low here
      o_first_status_output <= good1 & ~i_host_ctrl_mode[0];
      o_second_status_output <= good2 & ~i_host_ctrl_mode[1];
      o_fourth_status_output <= good4 & ~i_host_ctrl_mode[2];
      o_termination_enable <= good2;
    end
  end
endmodule

// [inc/reopg_defines.vh]
// Constants for the rail override and power-good delay block.
// Assumes a 100 MHz core clock and an 8-bit internal register port.
// Notes on behaviour
// - Second output delay bits 7:5 pick 0,5,10,15,20,50,100 ms.
// - Fourth output delay bits 4:2 use the same encoding as the second.
// - First output delay bits 1:0 pick 0, 5, 10 or 15 ms.
// - Count starts once all grouped rails regulate; good asserts at expiry.
// - Delays may deviate by ten percent; tests allow the tolerance.
// - Under host control, delay writes do not change that output.
// - Second delay still applies to its internal termination enable.
// - Disable bits 6, 5, 4 at 0 force their rails off.
// - Disable bit 7 covers the strap-selected shared rail.
// - Force-on bit at 0 lets the rail follow its pin request.
// - Force-on bit at 1 holds the rail on unless disabled.
// - Delay only matters for outputs in good or level-shift mode.
`ifndef REOPG_DEFINES_VH
`define REOPG_DEFINES_VH
`define REOPG_ADDR_DELAY 8'h9D
`define REOPG_ADDR_DISABLE 8'h9F
`define REOPG_ADDR_FORCE 8'hA0
`define REOPG_RST_DELAY 8'h00
`define REOPG_RST_DISABLE 8'h00
`define REOPG_RST_FORCE 8'h00
`define REOPG_RSVD_MASK 8'hF0
`define REOPG_F2_HI 7
`define REOPG_F2_LO 5
`define REOPG_F4_HI 4
`define REOPG_F4_LO 2
`define REOPG_F1_HI 1
`define REOPG_F1_LO 0
`define REOPG_DIS_SHARED 7
`define REOPG_DIS_SW2 6
`define REOPG_DIS_SW1 5
`define REOPG_DIS_TERM 4
`define REOPG_CLK_KHZ 100000
`define REOPG_MS_CYCLES (`REOPG_CLK_KHZ)
`define REOPG_TICKS_PER_MS 12'h00A
`define REOPG_D0_MS 8'h00
`define REOPG_D1_MS 8'h05
`define REOPG_D2_MS 8'h0A
`define REOPG_D3_MS 8'h0F
`define REOPG_D4_MS 8'h14
`define REOPG_D5_MS 8'h32
`define REOPG_D7_MS 8'h64
`endif

// [core/reopg_delay_timer.v]
// One power-good delay timer with a tenth-millisecond tick input.
// Assumes the tick comes from the shared divider on the same clock.
`timescale 1ns/10ps
`include "reopg_defines.vh"
module reopg_delay_timer
(
  input wire i_core_clk,
  input wire i_arst_n,
  input wire i_ms_tick,
  input wire i_qualified,
  input wire [7:0] i_delay_ms,
  output reg o_good
);
  reg [11:0] count_q;
  wire [11:0] limit;
  // Limit in tenths of a millisecond
  assign limit = {4'h0, i_delay_ms} * `REOPG_TICKS_PER_MS;
  // ==========================================
  // Count ticks after qualification
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count_q <= 12'h000;
      o_good <= 1'b0;
    end
    else if (!i_qualified)
    begin
      count_q <= 12'h000;
      o_good <= 1'b0;
    end
    else if (!o_good)
    begin
      if (count_q >= limit)
        o_good <= 1'b1;
      else if (i_ms_tick)
        count_q <= count_q + 12'h001;
    end
  end
endmodule

// [verification/reopg_monitor.sv]
// Port checks for the rail control block.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module reopg_monitor
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [15:0] i_pin_request,
  input wire logic i_shared_sel_linear,
  input wire logic [2:0] i_host_ctrl_mode,
  input wire logic [2:0] i_group_in_regulation,
  input wire logic [15:0] o_rail_enable,
  input wire logic o_first_status_output,
  input wire logic o_second_status_output,
  input wire logic o_fourth_status_output,
  input wire logic o_termination_enable
);
  // ====================
  // Checks
  wire wdis = i_reg_wr && i_reg_addr == 8'h9F;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  chk_sw1_off: assert property (
    wdis && !i_reg_wdata[5] ##1 !i_reg_wr [*2] |=> !o_rail_enable[6])
    else $error("first switch on while off");
  chk_shared_off: assert property (
    wdis && !i_reg_wdata[7] && i_shared_sel_linear ##1 !i_reg_wr [*2]
    |=> !o_rail_enable[10]) else $error("shared rail on while off");
  chk_force_on: assert property (
    i_reg_wr && i_reg_addr == 8'hA0 && i_reg_wdata[0] ##1 !i_reg_wr [*2]
    |=> o_rail_enable[0]) else $error("forced rail off");
  chk_pin_follow: assert property ($stable(i_pin_request) [*3]
    |-> o_rail_enable[15:12] == i_pin_request[15:12])
    else $error("rail ignores pin");
  chk_host_low: assert property (i_host_ctrl_mode[0] [*3]
    |-> !o_first_status_output) else $error("host output driven");
  chk_grp_drop: assert property (!i_group_in_regulation[1] [*6]
    |-> !o_second_status_output) else $error("good without group");
  chk_grp_four: assert property (!i_group_in_regulation[2] [*6]
    |-> !o_fourth_status_output) else $error("good without group");
  chk_term_same: assert property (!i_host_ctrl_mode[1] [*3]
    |-> o_termination_enable == o_second_status_output)
    else $error("termination differs");
endmodule
bind reopg_rail_ctrl reopg_monitor reopg_monitor_inst
(
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_pin_request(i_pin_request), .i_shared_sel_linear(i_shared_sel_linear),
  .i_host_ctrl_mode(i_host_ctrl_mode),
  .i_group_in_regulation(i_group_in_regulation),
  .o_rail_enable(o_rail_enable), .o_first_status_output(o_first_status_output),
  .o_second_status_output(o_second_status_output),
  .o_fourth_status_output(o_fourth_status_output),
  .o_termination_enable(o_termination_enable)
);

// [verification/reopg_host_model.sv]
// Host model issuing register write and read cycles.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/10ps
module reopg_host_model
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic o_reg_wr = 1'b0,
  output logic o_reg_rd = 1'b0,
  output logic [7:0] o_reg_addr = 8'h00,
  output logic [7:0] o_reg_wdata = 8'h00
);
  // ====================
  // Register cycles
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_core_clk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= (a == 8'h9F) ? (d & 8'hF0) : d;
    @(posedge i_core_clk);
    o_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_core_clk);
    o_reg_rd <= 1'b0;
    @(posedge i_core_clk);
    #1 d = i_reg_rdata;
  endtask
endmodule

// [verification/test_rail_enable_override_pg_delay.sv]
// Bench for the rail override and power-good delay block.
// Assumes the host model issues every register cycle.
`timescale 1ns/10ps
module test_rail_enable_override_pg_delay;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, term;
  logic [7:0] addr, wdata, rdata, d;
  logic [15:0] pins = 16'hFFFF;
  logic sel = 1'b1;
  logic [15:0] rails;
  logic [2:0] hmode = 3'h0;
  logic [2:0] grp = 3'h0;
  logic [2:0] gv;
  int err_count = 0;
  int total_checks = 0;
  int exp_ms[8] = '{0, 5, 10, 15, 20, 50, 100, 100};
  logic [7:0] ra[4] = '{8'h9D, 8'h9F, 8'hA0, 8'h9E};
  int t[3];
  int e;
  bit ok;
  initial
  begin
    forever #5 clk = ~clk;
  end
  reopg_rail_ctrl #(.MS_CYCLES(10)) reopg_rail_ctrl_inst
  (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_control_input_pins(6'h00), .i_pin_request(pins),
    .i_shared_sel_linear(sel), .i_host_ctrl_mode(hmode),
    .i_group_in_regulation(grp), .o_rail_enable(rails),
    .o_first_status_output(gv[0]), .o_second_status_output(gv[1]),
    .o_fourth_status_output(gv[2]), .o_termination_enable(term)
  );
  reopg_host_model reopg_host_model_inst
  (
    .i_core_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata)
  );
  // ====================
  // Helpers
  task automatic chk(input string n, input logic [15:0] ex, got);
    total_checks++;
    if (got !== ex)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic rl(input logic [15:0] ex);
    repeat (3) @(posedge clk);
    #1 chk("rails", ex, rails);
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ====================
  // Sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (exp_ms[c])
    begin
      reopg_host_model_inst.wr(8'h9D, {c[2:0], c[2:0], c[1:0]});
      reopg_host_model_inst.rd(8'h9D, d);
      chk("delay_reg", 16'({c[2:0], c[2:0], c[1:0]}), 16'(d));
      @(posedge clk);
      grp <= 3'h7;
      t = '{-1, -1, -1};
      for (int n = 0; n < 1200; n++)
      begin
        @(posedge clk);
        #1;
        foreach (t[k])
          if (t[k] < 0 && gv[k]) t[k] = n;
      end
      foreach (t[k])
      begin
        e = 10 * (k == 0 ? 5 * (c % 4) : exp_ms[c]);
        ok = t[k] >= 0 && t[k] >= e - e / 10 && t[k] <= e + e / 10 + 16;
        chk("delay", 16'(e), ok ? 16'(e) : 16'(t[k]));
      end
      @(posedge clk);
      grp <= 3'h0;
      repeat (8) @(posedge clk);
      #1 chk("good_drop", 16'h0, 16'(gv));
    end
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i])
    begin
      reopg_host_model_inst.rd(ra[i], d);
      chk("reg_reset", 16'h0, 16'(d));
    end
    rl(16'hF2BF);
    @(posedge clk);
    sel <= 1'b0;
    rl(16'hF4BF);
    @(posedge clk);
    sel <= 1'b1;
    reopg_host_model_inst.wr(8'h9F, 8'hFF);
    reopg_host_model_inst.rd(8'h9F, d);
    chk("disable_reg", 16'h00F0, 16'(d));
    rl(16'hFFFF);
    @(posedge clk);
    pins <= 16'h0000;
    reopg_host_model_inst.wr(8'hA0, 8'hFF);
    reopg_host_model_inst.rd(8'hA0, d);
    chk("force_reg", 16'h00FF, 16'(d));
    rl(16'h00FF);
    reopg_host_model_inst.wr(8'h9F, 8'h00);
    rl(16'h00BF);
    @(posedge clk);
    hmode <= 3'h7;
    grp <= 3'h7;
    repeat (12) @(posedge clk);
    #1 chk("host_mode", 16'h1, 16'({gv, term}));
    report_and_stop;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
endmodule
